/* clock_gating_cfg.svh */
// clock_gating_cfg.svh: offsets, bit positions and reset values of the clock gating block
// assumes a 32-bit word register port with byte offsets
`ifndef CLOCK_GATING_CFG_SVH
`define CLOCK_GATING_CFG_SVH
`define OFS_SYS_SET        8'h00
`define OFS_SYS_CLR        8'h04
`define OFS_SYS_STATE      8'h08
`define OFS_PER_SET        8'h10
`define OFS_PER_CLR        8'h14
`define OFS_PER_STATE      8'h18
`define OFS_USB_PHY_CFG    8'h1c
`define OFS_MAIN_OSC_CFG   8'h20
`define OFS_MAIN_FREQ      8'h24
`define OFS_PLL_CFG        8'h28
`define OFS_MCK_CFG        8'h30
`define OFS_USB_CFG        8'h38
`define OFS_SMD_CFG        8'h3c
`define OFS_PROG0_CFG      8'h40
`define OFS_PROG1_CFG      8'h44
`define OFS_INT_SET        8'h60
`define OFS_INT_CLR        8'h64
`define OFS_STATUS         8'h68
`define OFS_INT_MASK       8'h6c
`define OFS_PLL_PUMP       8'h80
`define OFS_WP_MODE        8'he4
`define OFS_WP_STATUS      8'he8
`define OFS_EVT_STATUS     8'hf0
`define OFS_EVT_MASK       8'hf4
`define OFS_PER_CTRL       9'h10c
`define BIT_PROC           0
`define BIT_DRAM           2
`define BIT_DOUBLE         3
`define BIT_SMD            4
`define BIT_UHOST          6
`define BIT_UDEV           7
`define BIT_PROG0          8
`define BIT_PROG1          9
`define SYS_MASK           32'h0000_03dd
`define SYS_SET_MASK       32'h0000_03dc
`define PER_MASK           32'hffff_fffc
`define SYS_STATE_RESET    32'h0000_0005
`define PER_STATE_RESET    32'h0000_0000
`define USB_PHY_RESET      32'h1020_0000
`define PLL_CFG_RESET      32'h0000_3f00
`define MCK_CFG_RESET      32'h0000_0001
`define STATUS_RESET       32'h0001_0008
`define PLL_PUMP_RESET     32'h0100_0100
`define WP_EN_BIT          0
`define WP_VIOL_BIT        0
`define WP_SRC_LSB         8
`define EVT_VIOL_BIT       0
`define EVT_WIDTH          1
`endif

/* clock_gating_pkg.sv */
// clock_gating_pkg.sv: types shared by the clock gating block
// assumes clock_gating_cfg.svh gives the numeric constants
package clock_gating_pkg;
  typedef logic [8:0]  addr_type;
  typedef logic [31:0] word_type;
  typedef struct packed {
    word_type sys_on;
    word_type per_on;
    word_type usb_phy;
    word_type main_osc;
    word_type main_freq;
    word_type pll_cfg;
    word_type mck_cfg;
    word_type usb_cfg;
    word_type smd_cfg;
    word_type prog0;
    word_type prog1;
    word_type int_mask;
    word_type pll_pump;
    word_type wp_mode;
    logic     viol_flag;
    logic [15:0] viol_src;
    logic [0:0]  evt_status;
    logic [0:0]  evt_mask;
    word_type per_ctrl;
    word_type rdata;
  } state_type;
endpackage : clock_gating_pkg

/* system_peripheral_clock_gating.sv */
// system_peripheral_clock_gating.sv: register-controlled system and peripheral clock gating
// assumes one clock domain, word register port, gates are enable-style (glitch free latch cells outside)
`include "clock_gating_cfg.svh"
module system_peripheral_clock_gating #(
  parameter logic [31:0] PER_IMPLEMENTED = 32'hffff_fffc
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rstn_in,
  input  wire clock_gating_pkg::addr_type addr_in,
  input  wire clock_gating_pkg::word_type wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  input  wire logic                       lcd_pixel_source_select_in,
  input  wire logic                       double_rate_master_clock_in,
  output clock_gating_pkg::word_type      rdata_out,
  output logic                            processor_clock_gate_out,
  output logic                            dram_clock_gate_out,
  output logic                            double_rate_clock_gate_out,
  output logic                            soft_modem_clock_gate_out,
  output logic                            usb_host_48mhz_clock_out,
  output logic                            usb_host_12mhz_clock_out,
  output logic                            usb_device_clock_gate_out,
  output logic                            prog_clock_out_0,
  output logic                            prog_clock_out_1,
  output clock_gating_pkg::word_type      peripheral_clock_bit_out,
  output logic                            lcd_pixel_clock_enable_out,
  output logic                            irq_out
);
  import clock_gating_pkg::*;

  state_type cur;
  state_type next_cur;
  logic      prot;
  logic      wr_hit_prot;
  word_type  rd_val;

  assign prot = cur.wp_mode[`WP_EN_BIT];

  always_comb begin
    wr_hit_prot = 1'b0;
    if (addr_in == {1'b0, `OFS_SYS_SET} || addr_in == {1'b0, `OFS_SYS_CLR}
        || addr_in == {1'b0, `OFS_PER_SET} || addr_in == {1'b0, `OFS_MAIN_FREQ}
        || addr_in == {1'b0, `OFS_PLL_CFG} || addr_in == {1'b0, `OFS_MCK_CFG}
        || addr_in == {1'b0, `OFS_USB_CFG} || addr_in == {1'b0, `OFS_PROG0_CFG}
        || addr_in == {1'b0, `OFS_PROG1_CFG} || addr_in == {1'b0, `OFS_PLL_PUMP}) begin
      wr_hit_prot = 1'b1;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_in == {1'b0, `OFS_SYS_STATE}) begin
      rd_val = cur.sys_on;
    end else if (addr_in == {1'b0, `OFS_PER_STATE}) begin
      rd_val = cur.per_on;
    end else if (addr_in == {1'b0, `OFS_USB_PHY_CFG}) begin
      rd_val = cur.usb_phy;
    end else if (addr_in == {1'b0, `OFS_MAIN_OSC_CFG}) begin
      rd_val = cur.main_osc;
    end else if (addr_in == {1'b0, `OFS_MAIN_FREQ}) begin
      rd_val = cur.main_freq;
    end else if (addr_in == {1'b0, `OFS_PLL_CFG}) begin
      rd_val = cur.pll_cfg;
    end else if (addr_in == {1'b0, `OFS_MCK_CFG}) begin
      rd_val = cur.mck_cfg;
    end else if (addr_in == {1'b0, `OFS_USB_CFG}) begin
      rd_val = cur.usb_cfg;
    end else if (addr_in == {1'b0, `OFS_SMD_CFG}) begin
      rd_val = cur.smd_cfg;
    end else if (addr_in == {1'b0, `OFS_PROG0_CFG}) begin
      rd_val = cur.prog0;
    end else if (addr_in == {1'b0, `OFS_PROG1_CFG}) begin
      rd_val = cur.prog1;
    end else if (addr_in == {1'b0, `OFS_STATUS}) begin
      rd_val = `STATUS_RESET;
    end else if (addr_in == {1'b0, `OFS_INT_MASK}) begin
      rd_val = cur.int_mask;
    end else if (addr_in == {1'b0, `OFS_PLL_PUMP}) begin
      rd_val = cur.pll_pump;
    end else if (addr_in == {1'b0, `OFS_WP_MODE}) begin
      rd_val = cur.wp_mode;
    end else if (addr_in == {1'b0, `OFS_WP_STATUS}) begin
      rd_val = {cur.viol_src, 15'h0000, cur.viol_flag};
    end else if (addr_in == {1'b0, `OFS_EVT_STATUS}) begin
      rd_val = {31'h0000_0000, cur.evt_status};
    end else if (addr_in == {1'b0, `OFS_EVT_MASK}) begin
      rd_val = {31'h0000_0000, cur.evt_mask};
    end else if (addr_in == `OFS_PER_CTRL) begin
      rd_val = cur.per_ctrl;
    end
  end

  always_comb begin
    next_cur = cur;
    next_cur.rdata = rd_in ? rd_val : 32'h0000_0000;
    // clear on read first so a violation in a same-cycle write still lands
    if (rd_in && addr_in == {1'b0, `OFS_WP_STATUS}) begin
      next_cur.viol_flag = 1'b0;
    end
    if (wr_in && prot && wr_hit_prot) begin
      next_cur.viol_flag  = 1'b1;
      next_cur.viol_src   = {7'h00, addr_in};
      next_cur.evt_status = 1'b1;
    end else if (wr_in) begin
      if (addr_in == {1'b0, `OFS_SYS_SET}) begin
        // no processor bit here: it cannot be restarted from software
        next_cur.sys_on = cur.sys_on | (wdata_in & `SYS_SET_MASK);
      end else if (addr_in == {1'b0, `OFS_SYS_CLR}) begin
        next_cur.sys_on = cur.sys_on & ~(wdata_in & `SYS_MASK);
      end else if (addr_in == {1'b0, `OFS_PER_SET}) begin
        next_cur.per_on = cur.per_on | (wdata_in & `PER_MASK & PER_IMPLEMENTED);
      end else if (addr_in == {1'b0, `OFS_PER_CLR}) begin
        next_cur.per_on = cur.per_on & ~(wdata_in & `PER_MASK & PER_IMPLEMENTED);
      end else if (addr_in == {1'b0, `OFS_USB_PHY_CFG}) begin
        next_cur.usb_phy = wdata_in;
      end else if (addr_in == {1'b0, `OFS_MAIN_OSC_CFG}) begin
        next_cur.main_osc = wdata_in;
      end else if (addr_in == {1'b0, `OFS_MAIN_FREQ}) begin
        next_cur.main_freq = wdata_in;
      end else if (addr_in == {1'b0, `OFS_PLL_CFG}) begin
        next_cur.pll_cfg = wdata_in;
      end else if (addr_in == {1'b0, `OFS_MCK_CFG}) begin
        next_cur.mck_cfg = wdata_in;
      end else if (addr_in == {1'b0, `OFS_USB_CFG}) begin
        next_cur.usb_cfg = wdata_in;
      end else if (addr_in == {1'b0, `OFS_SMD_CFG}) begin
        next_cur.smd_cfg = wdata_in;
      end else if (addr_in == {1'b0, `OFS_PROG0_CFG}) begin
        next_cur.prog0 = wdata_in;
      end else if (addr_in == {1'b0, `OFS_PROG1_CFG}) begin
        next_cur.prog1 = wdata_in;
      end else if (addr_in == {1'b0, `OFS_INT_SET}) begin
        next_cur.int_mask = cur.int_mask | wdata_in;
      end else if (addr_in == {1'b0, `OFS_INT_CLR}) begin
        next_cur.int_mask = cur.int_mask & ~wdata_in;
      end else if (addr_in == {1'b0, `OFS_PLL_PUMP}) begin
        next_cur.pll_pump = wdata_in;
      end else if (addr_in == {1'b0, `OFS_WP_MODE}) begin
        next_cur.wp_mode = wdata_in;
      end else if (addr_in == {1'b0, `OFS_EVT_STATUS}) begin
        next_cur.evt_status = cur.evt_status & ~wdata_in[0:0];
      end else if (addr_in == {1'b0, `OFS_EVT_MASK}) begin
        next_cur.evt_mask = wdata_in[0:0];
      end else if (addr_in == `OFS_PER_CTRL) begin
        next_cur.per_ctrl = wdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur            <= '0;
      cur.sys_on     <= `SYS_STATE_RESET;
      cur.per_on     <= `PER_STATE_RESET;
      cur.usb_phy    <= `USB_PHY_RESET;
      cur.pll_cfg    <= `PLL_CFG_RESET;
      cur.mck_cfg    <= `MCK_CFG_RESET;
      cur.pll_pump   <= `PLL_PUMP_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // enables only; the actual gate cells latch them on the low phase, keeping outputs glitch free
  assign rdata_out                  = cur.rdata;
  assign processor_clock_gate_out   = cur.sys_on[`BIT_PROC];
  assign dram_clock_gate_out        = cur.sys_on[`BIT_DRAM];
  assign double_rate_clock_gate_out = cur.sys_on[`BIT_DOUBLE];
  assign soft_modem_clock_gate_out  = cur.sys_on[`BIT_SMD];
  assign usb_host_48mhz_clock_out   = cur.sys_on[`BIT_UHOST];
  assign usb_host_12mhz_clock_out   = cur.sys_on[`BIT_UHOST];
  assign usb_device_clock_gate_out  = cur.sys_on[`BIT_UDEV];
  assign prog_clock_out_0           = cur.sys_on[`BIT_PROG0];
  assign prog_clock_out_1           = cur.sys_on[`BIT_PROG1];
  assign peripheral_clock_bit_out   = cur.per_on;
  assign lcd_pixel_clock_enable_out = cur.sys_on[`BIT_DOUBLE] & lcd_pixel_source_select_in
                                      & double_rate_master_clock_in;
  assign irq_out = |(cur.evt_status & cur.evt_mask);
endmodule : system_peripheral_clock_gating

/* clock_gating_checker.sv */
// clock_gating_checker.sv: port assertions for the clock gating block
// assumes it is bound to the block top and sees only its ports
module clock_gating_checker
  import clock_gating_pkg::*;
(
  input wire logic                       sys_clk_in,
  input wire logic                       rstn_in,
  input wire clock_gating_pkg::addr_type addr_in,
  input wire clock_gating_pkg::word_type wdata_in,
  input wire logic                       wr_in,
  input wire logic                       rd_in,
  input wire logic                       lcd_pixel_source_select_in,
  input wire logic                       double_rate_master_clock_in,
  input wire clock_gating_pkg::word_type rdata_out,
  input wire logic                       processor_clock_gate_out,
  input wire logic                       dram_clock_gate_out,
  input wire logic                       double_rate_clock_gate_out,
  input wire logic                       soft_modem_clock_gate_out,
  input wire logic                       usb_host_48mhz_clock_out,
  input wire logic                       usb_host_12mhz_clock_out,
  input wire logic                       usb_device_clock_gate_out,
  input wire logic                       prog_clock_out_0,
  input wire logic                       prog_clock_out_1,
  input wire clock_gating_pkg::word_type peripheral_clock_bit_out,
  input wire logic                       lcd_pixel_clock_enable_out
);
  // own copy of the protect bit, since the checker cannot see inside
  logic wp_on;
  wire  wsys = wr_in && !wp_on;
  wire [9:0] gates = {prog_clock_out_1, prog_clock_out_0, usb_device_clock_gate_out, usb_host_48mhz_clock_out, 1'b0,
                      soft_modem_clock_gate_out, double_rate_clock_gate_out, dram_clock_gate_out, 1'b0,
                      processor_clock_gate_out};
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_on <= 1'b0;
    end else if (wr_in && addr_in == 9'h0e4) begin
      wp_on <= wdata_in[0];
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  a_dram_set: assert property (wsys && addr_in == 9'h000 && wdata_in[2] |=> dram_clock_gate_out)
    else $error("dram gate not set");
  a_dram_clear: assert property (wsys && addr_in == 9'h004 && wdata_in[2] |=> !dram_clock_gate_out)
    else $error("dram gate not cleared");
  a_double_set: assert property (wsys && addr_in == 9'h000 && wdata_in[3] |=> double_rate_clock_gate_out)
    else $error("double rate gate not set");
  a_usb_pair: assert property (usb_host_48mhz_clock_out == usb_host_12mhz_clock_out)
    else $error("usb host clocks split");
  a_proc_no_set: assert property (wr_in && addr_in == 9'h000 |=> $stable(processor_clock_gate_out))
    else $error("processor gate moved by set write");
  a_proc_stop: assert property (wsys && addr_in == 9'h004 && wdata_in[0] |=> !processor_clock_gate_out [*2])
    else $error("processor gate not stopped");
  a_protect_hold: assert property (wr_in && wp_on && (addr_in == 9'h000 || addr_in == 9'h004 || addr_in == 9'h010)
    |=> $stable({peripheral_clock_bit_out, gates}))
    else $error("protected write changed a gate");
  a_state_read: assert property (rd_in && addr_in == 9'h008 |=> rdata_out == {22'h0, $past(gates)})
    else $error("system state read mismatch");
  a_per_read: assert property (rd_in && addr_in == 9'h018 |=> rdata_out == $past(peripheral_clock_bit_out))
    else $error("peripheral state read mismatch");
  a_per_low: assert property (peripheral_clock_bit_out[1:0] == 2'b00)
    else $error("unused peripheral bits on");
  a_lcd_source: assert property (lcd_pixel_clock_enable_out == (double_rate_clock_gate_out
    && lcd_pixel_source_select_in && double_rate_master_clock_in))
    else $error("lcd pixel enable wrong");
endmodule : clock_gating_checker

/* system_peripheral_clock_gating_tb.sv */
// system_peripheral_clock_gating_tb.sv: self-checking bench for the clock gating block
// assumes the default peripheral mask and the register map of the block
module system_peripheral_clock_gating_tb;
  import clock_gating_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic     sys_clk_in, rstn_in, wr_in, rd_in, lcd_pixel_source_select_in, double_rate_master_clock_in;
  addr_type addr_in;
  word_type wdata_in, rdata_out, peripheral_clock_bit_out, sys_exp, per_exp;
  logic     processor_clock_gate_out, dram_clock_gate_out, double_rate_clock_gate_out, soft_modem_clock_gate_out;
  logic     usb_host_48mhz_clock_out, usb_host_12mhz_clock_out, usb_device_clock_gate_out, irq_out;
  logic     prog_clock_out_0, prog_clock_out_1, lcd_pixel_clock_enable_out;
  int       num_errors, num_checks;
  int       bits[7] = '{2, 3, 4, 6, 7, 8, 9};
  wire word_type gates = {22'h0, prog_clock_out_1, prog_clock_out_0, usb_device_clock_gate_out,
    usb_host_12mhz_clock_out, 1'b0, soft_modem_clock_gate_out, double_rate_clock_gate_out, dram_clock_gate_out,
    1'b0, processor_clock_gate_out};
  system_peripheral_clock_gating system_peripheral_clock_gating_i (.*);
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string n, input word_type e, input word_type g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input addr_type a, input word_type d);
    @(posedge sys_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input addr_type a, input word_type e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk("read data", e, rdata_out);
  endtask : rd
  task automatic test_reset();
    rd(9'h008, 32'h0000_0005);
    rd(9'h018, 32'h0000_0000);
    rd(9'h068, 32'h0001_0008);
    rd(9'h06c, 32'h0000_0000);
    rd(9'h00c, 32'h0000_0000);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_sys();
    sys_exp = 32'h0000_0005;
    wr(9'h000, 32'h0000_0001);
    chk("gates", sys_exp, gates);
    foreach (bits[i]) begin
      wr(9'h000, 32'h1 << bits[i]);
      sys_exp |= 32'h1 << bits[i];
      rd(9'h008, sys_exp);
      wr(9'h004, 32'h0);
      chk("gates", sys_exp, gates);
      wr(9'h004, 32'h1 << bits[i]);
      sys_exp &= ~(32'h1 << bits[i]);
      chk("gates", sys_exp, gates);
    end
    wr(9'h004, 32'h0000_0001);
    rd(9'h008, 32'h0);
    $display("test_sys done");
  endtask : test_sys
  task automatic test_per();
    per_exp = 32'hffff_fffc;
    wr(9'h010, 32'hffff_ffff);
    rd(9'h018, per_exp);
    wr(9'h014, 32'h0000_ff0f);
    per_exp &= 32'hffff_00f0;
    chk("peripheral", per_exp, peripheral_clock_bit_out);
    $display("test_per done");
  endtask : test_per
  task automatic test_protect();
    wr(9'h0e4, 32'h1);
    wr(9'h000, 32'h0000_03dc);
    wr(9'h004, 32'h0000_03dd);
    wr(9'h010, 32'hffff_ffff);
    rd(9'h018, per_exp);
    rd(9'h008, 32'h0);
    rd(9'h0e8, 32'h0010_0001);
    rd(9'h0e8, 32'h0010_0000);
    chk("irq", 32'h0, {31'h0, irq_out});
    wr(9'h0f4, 32'h1);
    chk("irq", 32'h1, {31'h0, irq_out});
    wr(9'h0f0, 32'h1);
    chk("irq", 32'h0, {31'h0, irq_out});
    wr(9'h0e4, 32'h0);
    wr(9'h060, 32'h0000_0005);
    wr(9'h064, 32'h0000_0001);
    wr(9'h068, 32'hffff_ffff);
    rd(9'h06c, 32'h0000_0004);
    rd(9'h068, 32'h0001_0008);
    $display("test_protect done");
  endtask : test_protect
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    final_report();
  end
  initial begin
    {rstn_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    lcd_pixel_source_select_in  = 1'b1;
    double_rate_master_clock_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    test_reset();
    test_sys();
    test_per();
    test_protect();
    final_report();
  end
endmodule : system_peripheral_clock_gating_tb
bind system_peripheral_clock_gating clock_gating_checker clock_gating_checker_i (.*);
